/* asx_top.sv */
// byte datapath core with its axi4-lite register front end
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asx_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [asx_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [asx_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [asx_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [asx_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status flags
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag
);
    import asx_pkg::*;

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_full_reg, w_full_reg, exec_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg, cmd_reg;
    logic [3:0] wstrb_reg;
    logic [7:0] work_reg;
    logic carry_reg, dc_reg, zero_reg;
    // file space is data, not control: left without reset
    logic [7:0] file_mem [FILE_DEPTH];

    asx_alu_if alu_bus ();
    asx_alu u_alu (.bus(alu_bus));

    // write channel decode
    wire aw_take = s_axi_awvalid & awready_reg;
    wire w_take = s_axi_wvalid & wready_reg;
    wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire b_done = bvalid_reg & s_axi_bready;
    wire hit_cmd = awaddr_reg[11:2] == CMD_OFF[11:2];
    wire hit_work = awaddr_reg[11:2] == WORK_OFF[11:2];
    wire hit_stat = awaddr_reg[11:2] == STAT_OFF[11:2];
    wire hit_file = awaddr_reg[11:9] == FILE_SEL;
    wire wr_ok = hit_cmd | hit_work | hit_stat | hit_file;
    wire wr_cmd = do_write & hit_cmd;
    wire byte0 = wstrb_reg[0];
    wire wr_work = do_write & hit_work & byte0;
    wire wr_stat = do_write & hit_stat & byte0;
    wire wr_file = do_write & hit_file & byte0;
    wire [FILE_AW-1:0] wr_idx = awaddr_reg[8:2];
    wire [31:0] wmask;
    wire [31:0] cmd_merge = (cmd_reg & ~wmask) | (wdata_reg & wmask);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
        end
    endgenerate

    // command fields drive the unit
    wire [FILE_AW-1:0] cmd_faddr = cmd_reg[CMD_FADDR_LSB +: FILE_AW];
    wire [7:0] fsel = file_mem[cmd_faddr];
    assign alu_bus.work = work_reg;
    assign alu_bus.file_val = fsel;
    assign alu_bus.literal = cmd_reg[CMD_LIT_LSB +: 8];
    assign alu_bus.op = asx_op_t'(cmd_reg[CMD_OP_LSB +: 2]);
    assign alu_bus.dest = cmd_reg[CMD_DEST_BIT];

    wire exec_file = exec_reg & alu_bus.to_file;
    wire exec_work = exec_reg & ~alu_bus.to_file;
    wire [7:0] work_next = exec_work ? alu_bus.result
                         : wr_work ? wdata_reg[7:0] : work_reg;
    wire carry_next = (exec_reg & alu_bus.upd_c) ? alu_bus.carry
                    : wr_stat ? wdata_reg[STAT_C_BIT] : carry_reg;
    wire dc_next = (exec_reg & alu_bus.upd_dc) ? alu_bus.digit_carry
                 : wr_stat ? wdata_reg[STAT_DC_BIT] : dc_reg;
    wire zero_next = (exec_reg & alu_bus.upd_z) ? alu_bus.zero
                   : wr_stat ? wdata_reg[STAT_Z_BIT] : zero_reg;

    // read decode
    wire ar_take = s_axi_arvalid & arready_reg;
    wire [FILE_AW-1:0] rd_idx = s_axi_araddr[8:2];
    wire rd_cmd = s_axi_araddr[11:2] == CMD_OFF[11:2];
    wire rd_work = s_axi_araddr[11:2] == WORK_OFF[11:2];
    wire rd_stat = s_axi_araddr[11:2] == STAT_OFF[11:2];
    wire rd_file = s_axi_araddr[11:9] == FILE_SEL;
    wire [31:0] stat_word = {29'h0, zero_reg, dc_reg, carry_reg};
    wire [31:0] rdata_next = rd_cmd ? cmd_reg
                           : rd_work ? {24'h0, work_reg}
                           : rd_stat ? stat_word
                           : rd_file ? {24'h0, file_mem[rd_idx]} : 32'h0;
    wire rd_ok = rd_cmd | rd_work | rd_stat | rd_file;

    // write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_reg <= 1'b0;
                aw_full_reg <= 1'b1;
            end
            if (w_take) begin
                wready_reg <= 1'b0;
                w_full_reg <= 1'b1;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end
            if (b_done) begin
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_take) awaddr_reg <= s_axi_awaddr;
        if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel: one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rdata_next;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // core state; execution runs the cycle after a command write,
    // while the response is still out, so bus writes never collide
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_reg <= CMD_RST;
            exec_reg <= 1'b0;
            work_reg <= WORK_RST;
            carry_reg <= 1'b0;
            dc_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            exec_reg <= wr_cmd;
            if (wr_cmd) cmd_reg <= cmd_merge;
            work_reg <= work_next;
            carry_reg <= carry_next;
            dc_reg <= dc_next;
            zero_reg <= zero_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (exec_file) file_mem[cmd_faddr] <= alu_bus.result;
        else if (wr_file) file_mem[wr_idx] <= wdata_reg[7:0];
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign carry_flag = carry_reg;
    assign digit_carry_flag = dc_reg;
    assign zero_flag = zero_reg;

    sub_work_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SUB && !alu_bus.dest
        |=> work_reg == 8'($past(fsel) - $past(work_reg)))
        else $error("subtract result wrong");
    sub_carry_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SUB
        |=> carry_reg == ($past(work_reg) <= $past(fsel))
            && dc_reg == ($past(work_reg[3:0]) <= $past(fsel[3:0])))
        else $error("subtract carry flags wrong");
    dest_file_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.dest && alu_bus.op != ASX_OP_XORLIT
        |=> $stable(work_reg))
        else $error("file destination touched work register");
    xor_lit_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_XORLIT
        |=> work_reg == ($past(work_reg) ^ $past(alu_bus.literal))
            && $stable(carry_reg) && $stable(dc_reg))
        else $error("literal xor wrong");
    xor_file_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_XORFILE && !alu_bus.dest
        |=> work_reg == ($past(work_reg) ^ $past(fsel))
            && $stable(carry_reg) && $stable(dc_reg))
        else $error("file xor wrong");
    swap_flags_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SWAP
        |=> $stable(carry_reg) && $stable(dc_reg) && $stable(zero_reg))
        else $error("swap changed a flag");
    swap_work_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SWAP && !alu_bus.dest
        |=> work_reg == {$past(fsel[3:0]), $past(fsel[7:4])})
        else $error("swap result wrong");
    zero_flag_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op != ASX_OP_SWAP
        |=> zero_reg == ($past(alu_bus.result) == 8'h00))
        else $error("zero flag wrong");
    sub_file_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SUB && alu_bus.dest
        |=> fsel == 8'($past(fsel) - $past(work_reg)))
        else $error("subtract to file wrong");
    file_xor_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_XORFILE && alu_bus.dest
        |=> fsel == ($past(work_reg) ^ $past(fsel))
            && zero_reg == (fsel == 8'h00))
        else $error("file xor to file wrong");
    swap_file_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_SWAP && alu_bus.dest
        |=> fsel == {$past(fsel[3:0]), $past(fsel[7:4])})
        else $error("swap to file wrong");
    file_keep_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && !alu_bus.dest
        |=> $stable(fsel))
        else $error("work destination touched file");
    lit_file_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        exec_reg && alu_bus.op == ASX_OP_XORLIT
        |=> $stable(fsel))
        else $error("literal xor touched file");
    stat_write_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_stat
        |=> carry_reg == $past(wdata_reg[STAT_C_BIT])
            && dc_reg == $past(wdata_reg[STAT_DC_BIT])
            && zero_reg == $past(wdata_reg[STAT_Z_BIT]))
        else $error("status write wrong");
    write_resp_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        do_write
        |=> bvalid_reg
            && bresp_reg == ($past(wr_ok) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response wrong");
    read_resp_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take
        |=> rvalid_reg
            && rresp_reg == ($past(rd_ok) ? RESP_OKAY : RESP_SLVERR))
        else $error("read response wrong");
    write_busy_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        aw_full_reg || w_full_reg || bvalid_reg
        |-> !(awready_reg && wready_reg))
        else $error("second write accepted while busy");
    read_busy_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rvalid_reg
        |-> !arready_reg)
        else $error("second read accepted while busy");
endmodule
`default_nettype wire

/* asx_pkg.sv */
// constants and types shared by the byte datapath and its bus front end
// How it works
// - subtract-from-file computes file value minus work value, 8-bit two's complement
// - subtract carry is 0 when work exceeds file; digit carry likewise on low nibbles
// - destination bit 0 writes work register, 1 writes back file register 0..127
// - literal xor combines work with 8-bit literal, writes work, only zero flag
// - file xor combines work with file, writes destination, only zero flag updates
// - nibble swap exchanges file nibbles into the result, every flag stays unchanged
package asx_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FILE_DEPTH = 128;
    localparam int FILE_AW = 7;
    // register byte addresses
    localparam logic [11:0] CMD_OFF = 12'h000;
    localparam logic [11:0] WORK_OFF = 12'h004;
    localparam logic [11:0] STAT_OFF = 12'h008;
    localparam logic [2:0] FILE_SEL = 3'h1;
    // command fields
    localparam int CMD_LIT_LSB = 0;
    localparam int CMD_FADDR_LSB = 8;
    localparam int CMD_DEST_BIT = 16;
    localparam int CMD_OP_LSB = 24;
    // status fields
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT = 2;
    // reset values and responses
    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [1:0] {
        ASX_OP_SUB = 2'b00,
        ASX_OP_XORLIT = 2'b01,
        ASX_OP_XORFILE = 2'b10,
        ASX_OP_SWAP = 2'b11
    } asx_op_t;
endpackage

/* asx_alu_if.sv */
// operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface asx_alu_if;
    import asx_pkg::*;
    logic [7:0] work;
    logic [7:0] file_val;
    logic [7:0] literal;
    asx_op_t op;
    logic dest;
    logic [7:0] result;
    logic carry;
    logic digit_carry;
    logic zero;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic to_file;
    modport core (
        output work, file_val, literal, op, dest,
        input result, carry, digit_carry, zero, upd_c, upd_dc, upd_z, to_file
    );
    modport alu (
        input work, file_val, literal, op, dest,
        output result, carry, digit_carry, zero, upd_c, upd_dc, upd_z, to_file
    );
endinterface
`default_nettype wire

/* asx_alu.sv */
// combinational arithmetic unit for subtract, xor and nibble swap
`timescale 1ns/1ps
`default_nettype none
module asx_alu (
    // operands in, results out
    asx_alu_if.alu bus
);
    import asx_pkg::*;

    logic [8:0] diff_w;
    // borrow out of bit 8 is the inverted carry
    assign diff_w = {1'b0, bus.file_val} - {1'b0, bus.work};

    always_comb begin
        unique case (bus.op)
            ASX_OP_SUB: bus.result = diff_w[7:0];
            ASX_OP_XORLIT: bus.result = bus.work ^ bus.literal;
            ASX_OP_XORFILE:
                bus.result = bus.work ^ bus.file_val;
            ASX_OP_SWAP: bus.result = {bus.file_val[3:0],
                                       bus.file_val[7:4]};
        endcase
    end

    assign bus.carry = ~diff_w[8];
    assign bus.digit_carry = bus.work[3:0] <= bus.file_val[3:0];
    assign bus.zero = bus.result == 8'h00;
    assign bus.upd_c = bus.op == ASX_OP_SUB;
    assign bus.upd_dc = bus.op == ASX_OP_SUB;
    assign bus.upd_z = bus.op != ASX_OP_SWAP;
    // literal xor never writes the file
    assign bus.to_file = (bus.dest == DEST_FILE)
                         && (bus.op != ASX_OP_XORLIT);
endmodule
`default_nettype wire

/* alu_sub_xor_swap_ops_tb_top.sv */
// self-checking bench for the byte datapath behind its axi4-lite front end
`timescale 1ns/1ps
`default_nettype none
module alu_sub_xor_swap_ops_tb_top;
    import asx_pkg::*;
    localparam logic [11:0] FILE_BASE = 12'h200;
    localparam int MAX_CYC = 20000;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, c_fl, dc_fl, z_fl;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rnd, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int err_total, checked, cyc;
    int wv, fv, lit, res, fa, op, dst, c, dc, z, st;
    logic [31:0] wrd, frd, srd;
    asx_top uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .carry_flag(c_fl),
        .digit_carry_flag(dc_fl), .zero_flag(z_fl));
    initial begin
        aclk = 0;
        aresetn = 0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
    end
    always #12.5 aclk = ~aclk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction
    task automatic ck(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // master holds each channel until its own handshake edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tw, tb;
        tb = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1;
        bready <= 1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) bready <= 0;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic ta, tr;
        tr = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (tr) rready <= 0;
        end
    endtask
    // a hang is cut short here rather than left to the simulator
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        err_total = 0;
        checked = 0;
        cyc = 0;
        rnd = 32'h61e3_3f10;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(CMD_OFF, rv, rsp);
        ck("cmd_rst", rv, CMD_RST);
        rd(WORK_OFF, rv, rsp);
        ck("work_rst", rv, {24'h00_0000, WORK_RST});
        ck("flags_rst", {z_fl, dc_fl, c_fl}, 3'b000);
        $display("test reset done");
        wr(12'h100, 32'h1234_5678, rsp);
        ck("unmapped_bresp", rsp, RESP_SLVERR);
        rd(12'h100, rv, rsp);
        ck("unmapped_rresp", rsp, RESP_SLVERR);
        ck("unmapped_rdata", rv, 32'h0000_0000);
        $display("test unmapped done");
        for (int i = 0; i < 48; i++) begin
            rnd = lfsr(rnd);
            op = i % 4;
            // both ends of the file address range come first
            fa = (i < 4) ? 0 : (i < 8) ? 127 : rnd[6:0];
            fv = rnd[15:8];
            wv = (i % 5 == 0) ? fv : rnd[23:16];
            lit = rnd[31:24];
            dst = rnd[7];
            rnd = lfsr(rnd);
            z = rnd[2];
            dc = rnd[1];
            c = rnd[0];
            wr(FILE_BASE + 12'(4 * fa), 32'(fv), rsp);
            wr(WORK_OFF, 32'(wv), rsp);
            wr(STAT_OFF, 32'(rnd[2:0]), rsp);
            wr(CMD_OFF, {6'h00, 2'(op), 7'h00, 1'(dst), 1'b0, 7'(fa),
                         8'(lit)}, rsp);
            ck("cmd_bresp", rsp, RESP_OKAY);
            case (op)
                0: res = (fv - wv) & 255;
                1: res = wv ^ lit;
                2: res = wv ^ fv;
                default: res = ((fv & 15) << 4) | (fv >> 4);
            endcase
            if (op == 0) begin
                c = (wv <= fv);
                dc = ((wv & 15) <= (fv & 15));
            end
            if (op != 3) z = (res == 0);
            if (op == 1) dst = 0;
            if (dst == 1) fv = res;
            else wv = res;
            st = z * 4 + dc * 2 + c;
            @(negedge aclk);
            ck("flag_pins", {z_fl, dc_fl, c_fl}, 32'(st));
            rd(WORK_OFF, wrd, rsp);
            rd(FILE_BASE + 12'(4 * fa), frd, rsp);
            rd(STAT_OFF, srd, rsp);
            ck("stat_rresp", rsp, RESP_OKAY);
            ck("work", wrd, 32'(wv));
            ck("file", frd, 32'(fv));
            case (op)
                0: ck("sub_status", srd, 32'(st));
                1: ck("xorlit_status", srd, 32'(st));
                2: ck("xorfile_status", srd, 32'(st));
                default: ck("swap_status", srd, 32'(st));
            endcase
        end
        $display("test operations done");
        give_verdict();
    end
endmodule
`default_nettype wire
